// ==== hdl/tcmc_map.vh ====
// Constants of the timecode mode controller: modes, frame rate codes and timing counts.
// Assumes the includer runs on one 20 MHz clock.
`ifndef TCMC_MAP_VH
`define TCMC_MAP_VH

`define TCMC_MODE_OFF      3'h0
`define TCMC_MODE_FREE     3'h1
`define TCMC_MODE_RECRUN   3'h2
`define TCMC_MODE_RTC      3'h3
`define TCMC_MODE_EXT      3'h4
`define TCMC_MODE_EXTAUTO  3'h5

`define TCMC_FPS_23976     3'h0
`define TCMC_FPS_24        3'h1
`define TCMC_FPS_25        3'h2
`define TCMC_FPS_2997ND    3'h3
`define TCMC_FPS_2997D     3'h4
`define TCMC_FPS_30ND      3'h5
`define TCMC_FPS_30D       3'h6

// Frame rates in thousandths of a frame per second.
`define TCMC_RATE_23976    36'h000005DA8
`define TCMC_RATE_24       36'h000005DC0
`define TCMC_RATE_25       36'h0000061A8
`define TCMC_RATE_2997     36'h000007512
`define TCMC_RATE_30       36'h000007530

`define TCMC_CLK_HZ        20000000
`define TCMC_LOSS_MS       100

`define TCMC_TC_W          22
`define TCMC_TC_RESET      22'h000000
`define TCMC_FF_LSB        0
`define TCMC_SS_LSB        5
`define TCMC_MM_LSB        11
`define TCMC_HH_LSB        17
`define TCMC_DROP_SKIP     5'h02

`endif

// ==== hdl/tcmc_tc_counter.v ====
// Hours, minutes, seconds and frames counter with load and drop-frame skip.
// Assumes one tick per frame period and a load that overrides the tick.
`timescale 1ns/1ps
`default_nettype none
`include "tcmc_map.vh"
module tcmc_tc_counter (
  input  wire        i_clk,
  input  wire        i_reset_n,
  input  wire        i_load,
  input  wire [21:0] i_load_tc,
  input  wire        i_tick,
  input  wire [4:0]  i_max_ff,
  input  wire        i_drop,
  output wire [21:0] o_tc
);
  reg  [4:0] hh;
  reg  [5:0] mm;
  reg  [5:0] ss;
  reg  [4:0] ff;
  reg  [4:0] next_hh;
  reg  [5:0] next_mm;
  reg  [5:0] next_ss;
  reg  [4:0] next_ff;

  assign o_tc = {hh, mm, ss, ff};

  always @* begin
    next_hh = hh;
    next_mm = mm;
    next_ss = ss;
    next_ff = ff;
    if (ff >= i_max_ff) begin
      next_ff = 5'h00;
      if (ss >= 6'h3B) begin
        next_ss = 6'h00;
        if (mm >= 6'h3B) begin
          next_mm = 6'h00;
          next_hh = (hh >= 5'h17) ? 5'h00 : hh + 5'h01;
        end else begin
          next_mm = mm + 6'h01;
        end
        // Frames 0 and 1 are skipped at each minute except every tenth.
        if (i_drop && (next_mm % 6'h0A) != 6'h00) begin
          next_ff = `TCMC_DROP_SKIP;
        end
      end else begin
        next_ss = ss + 6'h01;
      end
    end else begin
      next_ff = ff + 5'h01;
    end
  end

  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      hh <= 5'h00;
      mm <= 6'h00;
      ss <= 6'h00;
      ff <= 5'h00;
    end else if (i_load) begin
      hh <= i_load_tc[`TCMC_HH_LSB +: 5];
      mm <= i_load_tc[`TCMC_MM_LSB +: 6];
      ss <= i_load_tc[`TCMC_SS_LSB +: 6];
      ff <= i_load_tc[`TCMC_FF_LSB +: 5];
    end else if (i_tick) begin
      hh <= next_hh;
      mm <= next_mm;
      ss <= next_ss;
      ff <= next_ff;
    end
  end
endmodule // tcmc_tc_counter
`default_nettype wire

// ==== hdl/tcmc_top.v ====
// Timecode mode controller: chooses how internal timecode runs, chases or is muted.
// Assumes the external receiver, recorder state and real-time clock share i_clk.
`timescale 1ns/1ps
`default_nettype none
`include "tcmc_map.vh"
module tcmc_top #(
  parameter LOSS_CYCLES = `TCMC_LOSS_MS * (`TCMC_CLK_HZ / 1000)
) (
  input  wire        i_clk,
  input  wire        i_reset_n,
  input  wire [2:0]  i_mode,
  input  wire [2:0]  i_fps_sel,
  input  wire        i_mute_opt,
  input  wire        i_clk_lock_opt,
  input  wire        i_fallback_opt,
  input  wire        i_recording,
  input  wire        i_paused,
  input  wire        i_rtc_changed,
  input  wire [21:0] i_rtc_tc,
  input  wire        i_jam,
  input  wire        i_ext_strobe,
  input  wire [21:0] i_ext_tc,
  output reg  [21:0] o_tc_out,
  output reg         o_tc_frame,
  output reg         o_tc_drive,
  output reg         o_tc_embed,
  output reg         o_ext_present,
  output reg         o_rec_start,
  output reg         o_rec_stop,
  output reg         o_audio_clk_ext
);
  // A frame is due each time the summed milli-frame rate reaches the clock rate times 1000.
  localparam [35:0] ACC_LIMIT = `TCMC_CLK_HZ * 36'd1000;
  localparam [31:0] LOSS_LIMIT = LOSS_CYCLES;

  reg  [35:0] acc;
  reg  [35:0] rate;
  reg  [4:0]  max_ff;
  reg         drop;
  reg         tick;
  reg  [31:0] loss_cnt;
  reg         ext_present;
  reg         ext_present_d;
  reg         started;
  reg  [2:0]  prev_mode;
  reg         run;
  reg         load;
  reg  [21:0] load_tc;
  wire [21:0] tc;
  wire [35:0] acc_sum;
  wire        ext_mode;
  wire        int_mode;
  wire        mute_eff;
  wire        fallback_eff;
  wire        mode_entry;
  wire        mode_on;

  assign ext_mode     = (i_mode == `TCMC_MODE_EXT) || (i_mode == `TCMC_MODE_EXTAUTO);
  assign int_mode     = (i_mode == `TCMC_MODE_FREE) || (i_mode == `TCMC_MODE_RECRUN) ||
                        (i_mode == `TCMC_MODE_RTC);
  assign mute_eff     = i_mute_opt && int_mode;
  assign fallback_eff = i_fallback_opt && ext_mode;
  assign mode_entry   = started && (prev_mode != i_mode);
  // Modes 6 and 7 fall in neither group and behave as off.
  assign mode_on      = ext_mode || int_mode;
  assign acc_sum      = acc + rate;

  // Frame rate and frame count per selection; unknown codes run at 30 non-drop.
  always @* begin
    rate   = `TCMC_RATE_30;
    max_ff = 5'h1D;
    drop   = 1'b0;
    case (i_fps_sel)
      `TCMC_FPS_23976: begin
        rate   = `TCMC_RATE_23976;
        max_ff = 5'h17;
      end
      `TCMC_FPS_24: begin
        rate   = `TCMC_RATE_24;
        max_ff = 5'h17;
      end
      `TCMC_FPS_25: begin
        rate   = `TCMC_RATE_25;
        max_ff = 5'h18;
      end
      `TCMC_FPS_2997ND: begin
        rate = `TCMC_RATE_2997;
      end
      `TCMC_FPS_2997D: begin
        rate = `TCMC_RATE_2997;
        drop = 1'b1;
      end
      `TCMC_FPS_30D: begin
        drop = 1'b1;
      end
      default: begin
        rate = `TCMC_RATE_30;
      end
    endcase
  end

  // Run enable per mode and the source of any load.
  always @* begin
    run     = 1'b0;
    load    = 1'b0;
    load_tc = i_ext_tc;
    case (i_mode)
      `TCMC_MODE_FREE: begin
        run = 1'b1;
      end
      `TCMC_MODE_RECRUN: begin
        run = i_recording;
      end
      `TCMC_MODE_RTC: begin
        run = 1'b1;
        if (!started || i_rtc_changed || mode_entry) begin
          load    = 1'b1;
          load_tc = i_rtc_tc;
        end
      end
      `TCMC_MODE_EXT, `TCMC_MODE_EXTAUTO: begin
        run  = fallback_eff && !ext_present;
        load = i_ext_strobe;
      end
      default: begin
        run = 1'b0;
      end
    endcase
    // A manual jam takes the external value in the internal modes.
    if (i_jam && int_mode && !load) begin
      load    = 1'b1;
      load_tc = i_ext_tc;
    end
  end

  // Fractional accumulator giving one tick per frame period.
  // A load restarts the period, so the loaded frame lasts a full frame time.
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      acc  <= 36'h000000000;
      tick <= 1'b0;
    end else if (load) begin
      acc  <= 36'h000000000;
      tick <= 1'b0;
    end else if (!run) begin
      tick <= 1'b0;
    end else if (acc_sum >= ACC_LIMIT) begin
      acc  <= acc_sum - ACC_LIMIT;
      tick <= 1'b1;
    end else begin
      acc  <= acc_sum;
      tick <= 1'b0;
    end
  end

  // External presence: lost after LOSS_CYCLES with no incoming frame.
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      loss_cnt    <= 32'h00000000;
      ext_present <= 1'b0;
    end else if (i_ext_strobe) begin
      loss_cnt    <= 32'h00000000;
      ext_present <= 1'b1;
    end else if (loss_cnt >= LOSS_LIMIT - 32'h00000001) begin
      ext_present <= 1'b0;
    end else begin
      loss_cnt <= loss_cnt + 32'h00000001;
    end
  end

  // Mode and presence history for entry and edge detection.
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      started       <= 1'b0;
      prev_mode     <= `TCMC_MODE_OFF;
      ext_present_d <= 1'b0;
    end else begin
      started       <= 1'b1;
      prev_mode     <= i_mode;
      ext_present_d <= ext_present;
    end
  end

  // The counter gives a load priority over a tick in the same cycle.
  tcmc_tc_counter u_counter (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_load    (load),
    .i_load_tc (load_tc),
    .i_tick    (tick),
    .i_max_ff  (max_ff),
    .i_drop    (drop),
    .o_tc      (tc)
  );

  // Every output is registered; the start and stop strobes last one cycle.
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_tc_out        <= `TCMC_TC_RESET;
      o_tc_frame      <= 1'b0;
      o_tc_drive      <= 1'b0;
      o_tc_embed      <= 1'b0;
      o_ext_present   <= 1'b0;
      o_rec_start     <= 1'b0;
      o_rec_stop      <= 1'b0;
      o_audio_clk_ext <= 1'b0;
    end else begin
      o_tc_out        <= tc;
      o_tc_frame      <= tick || load;
      o_tc_embed      <= mode_on;
      // Muting applies only when fully stopped, never while paused.
      o_tc_drive      <= mode_on &&
                         !(mute_eff && !i_recording && !i_paused);
      o_ext_present   <= ext_present;
      o_rec_start     <= (i_mode == `TCMC_MODE_EXTAUTO) && ext_present && !ext_present_d;
      o_rec_stop      <= (i_mode == `TCMC_MODE_EXTAUTO) && !ext_present && ext_present_d;
      o_audio_clk_ext <= i_clk_lock_opt && ext_mode && ext_present;
    end
  end
endmodule // tcmc_top
`default_nettype wire

// ==== verification/tcmc_ext_gen.sv ====
// Model of an external timecode source feeding decoded frames.
// Assumes the source shares the controller clock.
`timescale 1ns/1ps
`default_nettype none
module tcmc_ext_gen (
  input  wire logic        i_clk,
  input  wire logic        i_run,
  input  wire logic [7:0]  i_gap,
  output var  logic        o_strobe,
  output var  logic [21:0] o_tc,
  output var  logic [21:0] o_sent
);
  logic [7:0] cnt;
  logic [7:0] gap_q;
  logic       run_q;
  logic       fire;
  initial begin
    cnt = 8'h00;
    gap_q = 8'h00;
    run_q = 1'b0;
    fire = 1'b0;
    o_strobe = 1'b0;
    o_sent = 22'h021060;
    o_tc = ~o_sent;
  end
  // Run and gap are taken at the edge, so a change made after an edge acts from the next one.
  // Between frames the word shows the inverse of the last frame, not a held value.
  always @(posedge i_clk) begin
    run_q = i_run;
    gap_q = i_gap;
    #5;
    if (run_q) begin
      cnt = cnt + 8'h01;
    end
    fire = run_q && (cnt >= gap_q);
    if (fire) begin
      cnt = 8'h00;
      o_sent[4:0] = (o_sent[4:0] == 5'h18) ? 5'h00 : o_sent[4:0] + 5'h01;
    end
    o_strobe = fire;
    o_tc = fire ? o_sent : ~o_sent;
  end
endmodule // tcmc_ext_gen
`default_nettype wire

// ==== verification/tcmc_top_sva.sv ====
// Port checker for the timecode mode controller.
// Assumes binding into tcmc_top, one clock and an active-low reset.
`timescale 1ns/1ps
`default_nettype none
`include "tcmc_map.vh"
module tcmc_top_sva #(
  parameter LOSS_CYCLES = `TCMC_LOSS_MS * (`TCMC_CLK_HZ / 1000)
) (
  input wire logic        i_clk,
  input wire logic        i_reset_n,
  input wire logic [2:0]  i_mode,
  input wire logic        i_mute_opt,
  input wire logic        i_clk_lock_opt,
  input wire logic        i_recording,
  input wire logic        i_paused,
  input wire logic        i_rtc_changed,
  input wire logic [21:0] i_rtc_tc,
  input wire logic        i_jam,
  input wire logic        i_ext_strobe,
  input wire logic [21:0] i_ext_tc,
  input wire logic [21:0] o_tc_out,
  input wire logic        o_tc_drive,
  input wire logic        o_tc_embed,
  input wire logic        o_ext_present,
  input wire logic        o_rec_start,
  input wire logic        o_rec_stop,
  input wire logic        o_audio_clk_ext
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  wire int_m = i_mode == `TCMC_MODE_FREE || i_mode == `TCMC_MODE_RECRUN
               || i_mode == `TCMC_MODE_RTC;
  wire ext_m = i_mode == `TCMC_MODE_EXT || i_mode == `TCMC_MODE_EXTAUTO;
  // Cycles since the last incoming frame, saturating just past the loss limit.
  int unsigned quiet;
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      quiet <= 0;
    end else if (i_ext_strobe) begin
      quiet <= 0;
    end else if (quiet <= LOSS_CYCLES) begin
      quiet <= quiet + 1;
    end
  end
  sequence s_rtc_load;
    i_mode == `TCMC_MODE_RTC && (i_rtc_changed || $past(i_mode) != `TCMC_MODE_RTC);
  endsequence
  sequence s_ext_frame;
    ext_m && i_ext_strobe;
  endsequence
  a_off_silent: assert property (i_mode == `TCMC_MODE_OFF |=> !o_tc_drive && !o_tc_embed)
    else $error("output active while mode is off");
  a_free_drive: assert property (i_mode == `TCMC_MODE_FREE |=> o_tc_drive && o_tc_embed)
    else $error("free run output not driven");
  a_mute_stop: assert property (int_m && i_mute_opt && !i_recording && !i_paused |=> !o_tc_drive)
    else $error("muted output driven while stopped");
  a_mute_pause: assert property (int_m && i_mute_opt && i_paused |=> o_tc_drive)
    else $error("output silent while paused");
  a_mute_ignored: assert property (ext_m |=> o_tc_drive)
    else $error("mute acted in an external mode");
  a_recrun_hold: assert property (
    (i_mode == `TCMC_MODE_RECRUN && !i_recording && !i_jam)[*4] |=> $stable(o_tc_out))
    else $error("record run moved while stopped");
  a_rtc_load: assert property (s_rtc_load |-> ##2 o_tc_out == $past(i_rtc_tc, 2))
    else $error("clock value not loaded");
  a_ext_chase: assert property (s_ext_frame |-> ##2 o_tc_out == $past(i_ext_tc, 2))
    else $error("external frame not followed");
  a_ext_seen: assert property (s_ext_frame |-> ##2 o_ext_present)
    else $error("external frame not detected");
  a_auto_start: assert property (
    $past(i_mode) == `TCMC_MODE_EXTAUTO && $rose(o_ext_present) |-> o_rec_start)
    else $error("auto record did not start");
  a_auto_stop: assert property (
    $past(i_mode) == `TCMC_MODE_EXTAUTO && $fell(o_ext_present) |-> o_rec_stop)
    else $error("auto record did not stop");
  a_loss_time: assert property ($fell(o_ext_present) |-> quiet == LOSS_CYCLES + 1)
    else $error("presence lost at the wrong time");
  a_lock_mode: assert property (o_audio_clk_ext |-> $past(ext_m) && $past(i_clk_lock_opt))
    else $error("audio clock locked outside external modes");
  a_lock_drop: assert property ($fell(o_ext_present) |-> !o_audio_clk_ext)
    else $error("audio clock stayed external after loss");
endmodule // tcmc_top_sva
bind tcmc_top tcmc_top_sva #(.LOSS_CYCLES(LOSS_CYCLES)) u_sva (.i_clk(i_clk),
  .i_reset_n(i_reset_n), .i_mode(i_mode), .i_mute_opt(i_mute_opt),
  .i_clk_lock_opt(i_clk_lock_opt), .i_recording(i_recording), .i_paused(i_paused),
  .i_rtc_changed(i_rtc_changed), .i_rtc_tc(i_rtc_tc), .i_jam(i_jam),
  .i_ext_strobe(i_ext_strobe), .i_ext_tc(i_ext_tc), .o_tc_out(o_tc_out),
  .o_tc_drive(o_tc_drive), .o_tc_embed(o_tc_embed), .o_ext_present(o_ext_present),
  .o_rec_start(o_rec_start), .o_rec_stop(o_rec_stop), .o_audio_clk_ext(o_audio_clk_ext));
`default_nettype wire

// ==== verification/tcmc_top_tb_top.sv ====
// Self-checking bench for the timecode mode controller.
// Assumes the external source model and a shortened loss timeout.
`timescale 1ns/1ps
`default_nettype none
module tcmc_top_tb_top;
  localparam LOSS = 50;
  logic clk, rst_n, mute, lock, fb, rec, pau, chg, jam, run, stb, frm, drv, emb, pres, rs, rp, ack;
  logic [2:0]  mode, fps;
  logic [21:0] rtc, ext, tco, sent, exp_v;
  logic [7:0]  gap;
  logic [15:0] lfsr;
  int errors, cmp_count, starts, stops;
  tcmc_top #(.LOSS_CYCLES(LOSS)) dut_u (.i_clk(clk), .i_reset_n(rst_n), .i_mode(mode),
    .i_fps_sel(fps), .i_mute_opt(mute), .i_clk_lock_opt(lock), .i_fallback_opt(fb),
    .i_recording(rec), .i_paused(pau), .i_rtc_changed(chg), .i_rtc_tc(rtc), .i_jam(jam),
    .i_ext_strobe(stb), .i_ext_tc(ext), .o_tc_out(tco), .o_tc_frame(frm), .o_tc_drive(drv),
    .o_tc_embed(emb), .o_ext_present(pres), .o_rec_start(rs), .o_rec_stop(rp),
    .o_audio_clk_ext(ack));
  tcmc_ext_gen gen_u (.i_clk(clk), .i_run(run), .i_gap(gap), .o_strobe(stb), .o_tc(ext),
    .o_sent(sent));
  function automatic logic [15:0] next_rand(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic exp_drive(input logic [2:0] m, input logic mu, r, p);
    return m != 3'h0 && m < 3'h6 && !(mu && m < 3'h4 && !r && !p);
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask
  task automatic check(input string what, input logic [21:0] e, got);
    cmp_count++;
    if (got !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, e, got);
    end
  endtask
  task automatic stop_test;
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    starts += int'(rs === 1'b1);
    stops += int'(rp === 1'b1);
  end
  initial begin
    #(50 * 20000);
    errors++;
    stop_test();
  end
  initial begin
    {mode, fps, mute, lock, fb, rec, pau, chg, jam, run} = '0;
    rtc = 22'h000000;
    gap = 8'h03;
    lfsr = 16'h36FA;
    rst_n = 1'b0;
    tick(12);
    rst_n = 1'b1;
    for (int k = 0; k < 60; k++) begin
      lfsr = next_rand(lfsr);
      {fb, lock, fps, pau, rec, mute, mode} = lfsr[10:0];
      rtc = {5'h01, 1'b0, lfsr[14:10], 6'h0A, 5'h03};
      tick(2);
      check("drive", exp_drive(mode, mute, rec, pau), drv);
      check("embed", mode != 3'h0 && mode < 3'h6, emb);
    end
    $display("random mode test done");
    {mode, rec, pau, mute, lock} = '0;
    rtc = 22'h0AF143;
    tick(2);
    mode = 3'h3;
    tick(2);
    check("rtc entry", 22'h0AF143, tco);
    rtc = 22'h0AF2A4;
    chg = 1'b1;
    tick(1);
    chg = 1'b0;
    rtc = 22'h000000;
    tick(3);
    check("rtc change", 22'h0AF2A4, tco);
    mode = 3'h2;
    tick(4);
    check("recrun entry", 22'h0AF2A4, tco);
    jam = 1'b1;
    exp_v = ext;
    tick(1);
    check("frame", 22'h1, frm);
    jam = 1'b0;
    tick(5);
    check("recrun hold", exp_v, tco);
    $display("internal load test done");
    {mode, lock, fb, run} = {3'h4, 3'b111};
    tick(20);
    check("present", 22'h1, pres);
    check("lock on", 22'h1, ack);
    run = 1'b0;
    tick(4);
    check("chase", sent, tco);
    mode = 3'h1;
    tick(2);
    check("lock internal", 22'h0, ack);
    mode = 3'h4;
    tick(LOSS + 6);
    check("lost", 22'h0, pres);
    check("lock lost", 22'h0, ack);
    $display("external chase test done");
    {mode, gap, run} = {3'h5, 8'h28, 1'b1};
    tick(200);
    run = 1'b0;
    tick(LOSS + 50);
    check("rec starts", 22'h1, 22'(starts));
    check("rec stops", 22'h1, 22'(stops));
    $display("auto record test done");
    stop_test();
  end
endmodule // tcmc_top_tb_top
`default_nettype wire
